// ---- bench/field_model.sv ----
// far side model: trigger pool, panel clear key, alarm and status lines
// assumes the bench calls drive from its clocked stimulus process
`timescale 1ns/1ns
`include "led_map.svh"
module field_model (
   input  wire logic                CLK,
   output logic      [`NUM_SIG-1:0] SIGNALS,
   output logic      [`NUM_PIN-1:0] PINS
);
   initial begin
      SIGNALS = '0;
      PINS = '0;
   end
   // levels change just after an edge and stand until the next call
   task automatic drive(input logic [`NUM_SIG-1:0] s, input logic [`NUM_PIN-1:0] p);
      @(posedge CLK);
      SIGNALS <= s;
      PINS <= p;
   endtask
endmodule // field_model

// ---- bench/testbench.sv ----
// self-checking bench of the front panel indicator block
// assumes core/ on the include path and field_model as the far side
`timescale 1ns/1ns
`include "led_map.svh"
module testbench;
   typedef struct packed {
      logic [32:0] e;
      logic [32:0] m;
   } note_t;
   logic                CLK, RST_B, PWR_ON_RST_B, PSEL, PENABLE, PWRITE, PREADY;
   logic                PSLVERR, HEALTH_GREEN, SUPERVISION_CONTACT, snap, clr;
   logic [7:0]          PADDR, IND_GREEN, IND_RED, g;
   logic [31:0]         PWDATA, PRDATA;
   logic [`NUM_SIG-1:0] SIGNALS, sv;
   logic [`NUM_PIN-1:0] PINS;
   logic [5:0]          seen;
   logic [32:0]         got;
   logic [29:0]         sl [8];
   logic [9:0]          clrx = 10'b0101111011;
   note_t               q[$], nt;
   int                  mismatches, n_checks, seed;
   int ctl[10] = '{'h34, 'h34, 'h34, 'h35, 'h37, 'h34, 'h34, 'h34, 'h34, 'h34};
   int md[10] = '{'h52d, 'h52d, 'h52d, 'h52d, 'h52d, 'h52c, 'h52d, 'h52d, 'h52e, 'h52d};
   int sg[10] = '{0, 'h20, 'h40, 'h40, 0, 0, 0, 0, 0, 0};
   int pn[10] = '{'hd, 'hc, 'hc, 'hc, 'hc, 'hc, 'hc, 'he, 'he, 'hc};

   field_model i_field_model (.CLK(CLK), .SIGNALS(SIGNALS), .PINS(PINS));
   led_indicator_core #(.FLASH_HALF_CYC(4)) i_led_indicator_core (
      .CLK(CLK), .RST_B(RST_B), .PWR_ON_RST_B(PWR_ON_RST_B), .CE(1'b1),
      .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
      .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
      .SIGNALS(SIGNALS), .CLEAR_KEY(PINS[`PIN_KEY]), .PROT_ALARM(PINS[`PIN_ALARM]),
      .STARTUP_DONE(PINS[`PIN_START]), .PROT_ACTIVE(PINS[`PIN_PROT]),
      .INTERNAL_FAULT(PINS[`PIN_FAULT]), .IND_GREEN(IND_GREEN), .IND_RED(IND_RED),
      .HEALTH_GREEN(HEALTH_GREEN), .SUPERVISION_CONTACT(SUPERVISION_CONTACT)
   );

   initial begin
      CLK = 1'b0;
      forever #25 CLK = ~CLK;
   end

   // records whether lamp 0 and the health lamp were seen high and low
   always @(posedge CLK)
      if (clr)
         seen <= '0;
      else
         seen <= seen | {IND_GREEN[0], !IND_GREEN[0], IND_RED[0], !IND_RED[0],
                         HEALTH_GREEN, !HEALTH_GREEN};

   // takes the oldest note whenever read data or a lamp snapshot appears
   always @(posedge CLK) begin
      if (snap || (PSEL && PENABLE && PREADY && !PWRITE)) begin
         n_checks++;
         got = snap ? {9'h0, seen, IND_GREEN, IND_RED, HEALTH_GREEN, SUPERVISION_CONTACT}
                    : {PSLVERR, PRDATA};
         nt = (q.size() > 0) ? q.pop_front() : note_t'{33'h0, 33'h0};
         if ((got & nt.m) !== (nt.e & nt.m)) begin
            mismatches++;
            $display("mismatch at %0t: got %h want %h", $time, got, nt.e);
         end
      end
   end

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge CLK);
      mismatches++;
      $display("mismatch at %0t: timeout", $time);
      tally_and_finish;
   end

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge CLK);
      PSEL <= 1'b1;
      PENABLE <= 1'b0;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= d;
      @(posedge CLK);
      PENABLE <= 1'b1;
      do begin
         @(posedge CLK);
      end while (PREADY !== 1'b1);
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [32:0] e, input logic [32:0] m);
      q.push_back(note_t'{e, m});
      apb(1'b0, a, 32'h0);
   endtask

   task automatic look(input logic [32:0] e, input logic [32:0] m);
      q.push_back(note_t'{e, m});
      @(posedge CLK);
      snap <= 1'b1;
      @(posedge CLK);
      snap <= 1'b0;
   endtask

   task automatic settle;
      @(posedge CLK);
      clr <= 1'b1;
      @(posedge CLK);
      clr <= 1'b0;
      repeat (12) @(posedge CLK);
   endtask

   function automatic logic tr(input logic [29:0] s, input logic [15:0] v);
      logic t;
      t = 1'b0;
      for (int j = 0; j < 5; j++)
         t = t | (s[6*j+5] & (v[s[6*j+:4]] ^ s[6*j+4]));
      return t;
   endfunction

   initial begin
      {RST_B, PWR_ON_RST_B, PSEL, PENABLE, PWRITE, snap, clr} = '0;
      PADDR = '0;
      PWDATA = '0;
      seen = '0;
      seed = 18;
      mismatches = 0;
      n_checks = 0;
      repeat (4) @(posedge CLK);
      RST_B <= 1'b1;
      PWR_ON_RST_B <= 1'b1;
      settle;
      look(33'hc0000, 33'hffffd);
      rd(8'h00, 33'h0, '1);
      rd(8'h60, {1'b1, 32'h0}, '1);
      rd(8'h02, {1'b1, 32'h0}, '1);
      $display("boot test done");
      i_field_model.drive(16'h0, 5'hc);
      repeat (4) @(posedge CLK);
      settle;
      look(33'h80003, 33'hc0003);
      i_field_model.drive(16'h0, 5'h1c);
      repeat (5) @(posedge CLK);
      look(33'h2, 33'h3);
      i_field_model.drive(16'h0, 5'hc);
      $display("health test done");
      for (int i = 0; i < 8; i++) apb(1'b1, 8'(8'h14 + 8 * i), 32'h880);
      repeat (12) begin
         for (int i = 0; i < 8; i++) begin
            sl[i] = 30'($random(seed));
            apb(1'b1, 8'(8'h10 + 8 * i), {2'h0, sl[i]});
         end
         sv = 16'($random(seed));
         i_field_model.drive(sv, 5'hc);
         for (int i = 0; i < 8; i++) g[i] = tr(sl[i], sv);
         repeat (4) @(posedge CLK);
         look({15'h0, g, ~g, 2'h0}, {15'h0, 16'hffff, 2'h0});
      end
      $display("trigger test done");
      apb(1'b1, 8'h10, 32'h0);
      for (int c = 0; c < 5; c++) begin
         apb(1'b1, 8'h14, 32'(c) << 10);
         settle;
         look({9'h0, (c == 1 || c == 4), (c != 1), (c == 2 || c == 3), (c != 2), 2'h0,
               7'h0, (c == 1), 7'h0, (c == 2), 2'h0},
              {9'h0, 4'hf, 2'h0, 7'h0, (c < 3), 7'h0, (c < 3), 2'h0});
      end
      $display("colour test done");
      apb(1'b1, 8'h10, 32'h23);
      apb(1'b1, 8'h14, 32'h52d);
      apb(1'b1, 8'h00, 32'h34);
      // clear key while the trigger still stands must not clear
      i_field_model.drive(16'h8, 5'hd);
      repeat (5) @(posedge CLK);
      i_field_model.drive(16'h0, 5'hc);
      repeat (5) @(posedge CLK);
      look(33'h4, 33'h404);
      for (int a = 0; a < 10; a++) begin
         i_field_model.drive(16'h8, 5'hc);
         repeat (5) @(posedge CLK);
         i_field_model.drive(16'h0, 5'hc);
         repeat (5) @(posedge CLK);
         look(33'h4, 33'h404);
         rd(8'h04, 33'h1, 33'h1);
         apb(1'b1, 8'h00, ctl[a]);
         apb(1'b1, 8'h14, md[a]);
         apb(1'b1, 8'h10, (a == 6) ? 32'h0 : 32'h23);
         i_field_model.drive(16'(sg[a]), 5'(pn[a]));
         repeat (5) @(posedge CLK);
         i_field_model.drive(16'h0, 5'hc);
         if (a == 9) begin
            RST_B <= 1'b0;
            repeat (2) @(posedge CLK);
            RST_B <= 1'b1;
         end
         apb(1'b1, 8'h00, 32'h34);
         apb(1'b1, 8'h14, 32'h52d);
         apb(1'b1, 8'h10, 32'h23);
         repeat (4) @(posedge CLK);
         look({22'h0, clrx[a], 7'h0, !clrx[a], 2'h0}, 33'h404);
         i_field_model.drive(16'h0, 5'hd);
         repeat (4) @(posedge CLK);
      end
      $display("hold test done");
      tally_and_finish;
   end
endmodule // testbench

// ---- core/led_indicator_core.sv ----
// front panel indicator logic with APB register access
// assumes APB master on CLK; trigger, key, alarm and status lines are async pins
//
// Contract
// [RQ1] every indicator has five trigger slots, each one may be empty
// [RQ2] each slot has its own inversion applied before combining
// [RQ3] an empty slot always contributes zero, inversion ignored
// [RQ4] hold off: indicator state follows combined triggers without storage
// [RQ5] any true trigger selects the active colour code
// [RQ6] no true trigger selects the inactive colour code
// [RQ7] colour codes: off, green, red, red flashing, green flashing
// [RQ8] hold on: triggered state is stored until acknowledged
// [RQ9] clearing only happens once every trigger is inactive
// [RQ10] clear by panel, SCADA, own ack, hold switched off, all slots empty
// [RQ11] per-indicator ack signal acts only with hold on, only on itself
// [RQ12] held states survive warm and cold restarts; here only RST_B keeps them, a cold restart (PWR_ON_RST_B) clears them
// [RQ13] panel clear key acknowledges held indicators
// [RQ14] global ack signal clears all held indicators at once
// [RQ15] global ack and SCADA ack act only with group ack enabled
// [RQ16] alarm-ack mode indicators clear together on protection alarm
// [RQ17] health indicator flashes green in boot, steady green when protecting
// [RQ18] supervision contact energised only when started, protecting, fault free
// [RQ19] one shared flash rate; all indicators update on the system clock
`timescale 1ns/1ns
`include "led_map.svh"
module led_indicator_core #(
   parameter int unsigned FLASH_HALF_CYC = `FLASH_HALF_MS * (`CLK_HZ / 1000)
) (
   input  wire logic                CLK,
   input  wire logic                RST_B,
   input  wire logic                PWR_ON_RST_B,
   input  wire logic                CE,
   input  wire logic                PSEL,
   input  wire logic                PENABLE,
   input  wire logic                PWRITE,
   input  wire logic [7:0]          PADDR,
   input  wire logic [31:0]         PWDATA,
   output logic      [31:0]         PRDATA,
   output logic                     PREADY,
   output logic                     PSLVERR,
   input  wire logic [`NUM_SIG-1:0] SIGNALS,
   input  wire logic                CLEAR_KEY,
   input  wire logic                PROT_ALARM,
   input  wire logic                STARTUP_DONE,
   input  wire logic                PROT_ACTIVE,
   input  wire logic                INTERNAL_FAULT,
   output logic      [`NUM_IND-1:0] IND_GREEN,
   output logic      [`NUM_IND-1:0] IND_RED,
   output logic                     HEALTH_GREEN,
   output logic                     SUPERVISION_CONTACT
);
   led_pkg::state_t     s_reg;
   led_pkg::state_t     s_next;
   logic [`NUM_IND-1:0] trig;
   logic [`NUM_IND-1:0] ack;
   logic [`NUM_IND-1:0] assigned;
   logic [`NUM_IND-1:0] shown;
   logic [`NUM_IND-1:0] gr_g;
   logic [`NUM_IND-1:0] gr_r;
   logic                panel_ack;
   logic                group_ack;
   logic                alarm;
   logic                started;
   logic [7:0]          arr_off;
   logic                in_arr;
   logic                hit;
   logic                setup;
   logic                wr_en;
   logic [31:0]         rd;

   function automatic logic [1:0] col_gr(input led_pkg::colour_t c, input logic fl);
      logic [1:0] v;
      v = 2'h0;
      case (c)
         led_pkg::COL_GREEN:    v = 2'h2; // RQ7
         led_pkg::COL_RED:      v = 2'h1;
         led_pkg::COL_RED_FL:   v = {1'b0, fl};
         led_pkg::COL_GREEN_FL: v = {fl, 1'b0};
         default:               v = 2'h0;
      endcase
      return v;
   endfunction

   assign panel_ack = s_reg.pin_s2[`PIN_KEY]; // RQ13
   assign alarm     = s_reg.pin_s2[`PIN_ALARM];
   assign started   = s_reg.pin_s2[`PIN_START];
   // global source and SCADA clear all, only with group ack enabled
   assign group_ack = s_reg.group_en & (s_reg.scada | // RQ15
                      (s_reg.glb_used & s_reg.sig_s2[s_reg.glb_sel])); // RQ14

   for (genvar i = 0; i < `NUM_IND; i++) begin : g_ind
      logic [`NUM_SLOT-1:0] sv;
      logic [`NUM_SLOT-1:0] us;
      led_pkg::mode_t       m;
      logic [1:0]           c;
      assign m = s_reg.mode[i];
      for (genvar j = 0; j < `NUM_SLOT; j++) begin : g_slot // RQ1
         led_pkg::slot_t sl;
         assign sl    = s_reg.slots[i][j];
         assign sv[j] = sl.used & (s_reg.sig_s2[sl.sel] ^ sl.inv); // RQ2 RQ3
         assign us[j] = sl.used;
      end
      assign trig[i] = |sv; // RQ5
      assign assigned[i] = |us; // RQ10
      assign ack[i] = panel_ack | group_ack |
                      ((m.hold != led_pkg::HOLD_OFF) & m.ack_used & // RQ11
                       s_reg.sig_s2[m.ack_sel]) |
                      ((m.hold == led_pkg::HOLD_ALARM) & alarm); // RQ16
      // trigger term covers the cycle before the held bit is stored
      assign shown[i] = (m.hold == led_pkg::HOLD_OFF) ? trig[i] : // RQ4
                        (trig[i] | s_reg.held[i]); // RQ8
      assign c = shown[i] ? col_gr(m.on_colour_code, s_reg.flash) : // RQ5
                 col_gr(m.off_colour_code, s_reg.flash); // RQ6
      assign gr_g[i] = c[1];
      assign gr_r[i] = c[0];
   end

   // read data is latched in setup, so the access phase needs no wait state
   assign arr_off = PADDR - `REG_ARR_BASE;
   assign in_arr  = (PADDR >= `REG_ARR_BASE) & (PADDR < `REG_ARR_END);
   assign hit     = (PADDR[1:0] == 2'h0) &
                    (in_arr | (PADDR == `REG_CTRL) | (PADDR == `REG_STAT));
   assign setup   = PSEL & ~PENABLE;
   assign wr_en   = PSEL & PENABLE & PWRITE & hit;

   always_comb begin
      rd = 32'h0;
      if (PADDR == `REG_CTRL) begin
         rd[`CTRL_GRP_EN]               = s_reg.group_en;
         rd[`CTRL_GLB_USED]             = s_reg.glb_used;
         rd[`CTRL_GLB_LSB+3:`CTRL_GLB_LSB] = s_reg.glb_sel;
      end else if (PADDR == `REG_STAT) begin
         rd[`NUM_IND-1:0]                            = s_reg.held;
         rd[`STAT_SHOWN_LSB+`NUM_IND-1:`STAT_SHOWN_LSB] = shown;
         rd[`STAT_STARTED]                           = started;
         rd[`STAT_CONTACT]                           = s_reg.contact;
      end else if (in_arr & ~arr_off[2]) begin
         rd[6*`NUM_SLOT-1:0] = s_reg.slots[arr_off[5:3]];
      end else if (in_arr) begin
         rd[12:0] = s_reg.mode[arr_off[5:3]];
      end
   end

   always_comb begin
      s_next        = s_reg;
      s_next.sig_s1 = SIGNALS;
      s_next.sig_s2 = s_reg.sig_s1;
      s_next.pin_s1 = {INTERNAL_FAULT, PROT_ACTIVE, STARTUP_DONE, PROT_ALARM, CLEAR_KEY};
      s_next.pin_s2 = s_reg.pin_s1;
      s_next.scada  = 1'b0;
      if (setup) begin
         s_next.prdata  = rd;
         s_next.pslverr = ~hit;
      end
      if (wr_en) begin
         if (PADDR == `REG_CTRL) begin
            s_next.group_en = PWDATA[`CTRL_GRP_EN];
            s_next.scada    = PWDATA[`CTRL_SCADA];
            s_next.glb_used = PWDATA[`CTRL_GLB_USED];
            s_next.glb_sel  = PWDATA[`CTRL_GLB_LSB+3:`CTRL_GLB_LSB];
         end else if (in_arr & ~arr_off[2]) begin
            s_next.slots[arr_off[5:3]] = led_pkg::slots_t'(PWDATA[6*`NUM_SLOT-1:0]);
         end else if (in_arr) begin
            s_next.mode[arr_off[5:3]] = led_pkg::mode_t'(PWDATA[12:0]);
         end
      end
      // one counter for every flashing code, so all indicators flash in step
      if (s_reg.fcnt == `FLASH_W'(FLASH_HALF_CYC - 1)) begin // RQ19
         s_next.fcnt  = '0;
         s_next.flash = ~s_reg.flash;
      end else begin
         s_next.fcnt = s_reg.fcnt + `FLASH_W'(1);
      end
      for (int i = 0; i < `NUM_IND; i++) begin
         if (s_reg.mode[i].hold == led_pkg::HOLD_OFF) begin
            s_next.held[i] = 1'b0; // RQ10
         end else if (!assigned[i]) begin
            // no slot left that could still be active, so the clear is free
            s_next.held[i] = 1'b0; // RQ10
         end else begin
            // an active trigger holds or sets the bit, so ack cannot clear it
            s_next.held[i] = trig[i] | (s_reg.held[i] & ~ack[i]); // RQ8 RQ9 RQ10
         end
      end
      s_next.grn     = gr_g; // RQ19
      s_next.red     = gr_r;
      s_next.health  = (started & s_reg.pin_s2[`PIN_PROT]) | s_reg.flash; // RQ17
      s_next.contact = started & s_reg.pin_s2[`PIN_PROT] & // RQ18
                       ~s_reg.pin_s2[`PIN_FAULT];
   end

   always_ff @(posedge CLK) begin
      if (!PWR_ON_RST_B) begin
         s_reg <= '0;
      end else if (!RST_B) begin
         // restart: config and held states are kept
         s_reg.sig_s1  <= '0; // RQ12
         s_reg.sig_s2  <= '0;
         s_reg.pin_s1  <= '0;
         s_reg.pin_s2  <= '0;
         s_reg.scada   <= 1'b0;
         s_reg.grn     <= '0;
         s_reg.red     <= '0;
         s_reg.fcnt    <= '0;
         s_reg.flash   <= 1'b0;
         s_reg.health  <= 1'b0;
         s_reg.contact <= 1'b0;
         s_reg.prdata  <= 32'h0;
         s_reg.pslverr <= 1'b0;
      end else if (CE) begin
         s_reg <= s_next;
      end
   end

   assign PRDATA              = s_reg.prdata;
   assign PREADY              = 1'b1;
   assign PSLVERR             = s_reg.pslverr;
   assign IND_GREEN           = s_reg.grn;
   assign IND_RED             = s_reg.red;
   assign HEALTH_GREEN        = s_reg.health;
   assign SUPERVISION_CONTACT = s_reg.contact;

   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_B || !PWR_ON_RST_B || !CE);

   a_empty_slots_zero: assert property ( // RQ3
      (s_reg.slots[0][0].used | s_reg.slots[0][1].used | s_reg.slots[0][2].used |
       s_reg.slots[0][3].used | s_reg.slots[0][4].used) == 1'b0 |-> !trig[0])
      else $error("empty slots gave a true trigger");

   a_invert_slot: assert property ( // RQ2
      s_reg.slots[0][0].used && s_reg.slots[0][0].inv &&
      !s_reg.sig_s2[s_reg.slots[0][0].sel] |-> trig[0])
      else $error("inverted low signal did not trigger");

   a_track_no_hold: assert property ( // RQ4
      s_reg.mode[0].hold == led_pkg::HOLD_OFF |-> shown[0] == trig[0] ##1 !s_reg.held[0])
      else $error("indicator without hold does not track triggers");

   a_held_sticks: assert property ( // RQ8
      s_reg.mode[0].hold != led_pkg::HOLD_OFF && trig[0] ##1
      (s_reg.mode[0].hold != led_pkg::HOLD_OFF && !ack[0] && assigned[0]) [*3]
      |-> s_reg.held[0] && shown[0])
      else $error("held indicator lost its state");

   a_ack_blocked: assert property ( // RQ9
      s_reg.mode[0].hold != led_pkg::HOLD_OFF && trig[0] && ack[0] |=> s_reg.held[0])
      else $error("ack cleared indicator while trigger active");

   a_ack_clears: assert property ( // RQ10
      s_reg.mode[0].hold != led_pkg::HOLD_OFF && s_reg.held[0] && ack[0] && !trig[0]
      |=> !s_reg.held[0])
      else $error("ack did not clear held indicator");

   a_panel_clears: assert property ( // RQ13
      panel_ack && s_reg.held[0] && !trig[0] && s_reg.mode[0].hold == led_pkg::HOLD_ON
      |=> !s_reg.held[0])
      else $error("clear key did not acknowledge");

   a_group_gated: assert property ( // RQ15
      !s_reg.group_en && !panel_ack && assigned[0] &&
      !(s_reg.mode[0].ack_used && s_reg.sig_s2[s_reg.mode[0].ack_sel]) &&
      s_reg.held[0] && s_reg.mode[0].hold == led_pkg::HOLD_ON |=> s_reg.held[0])
      else $error("group ack acted while disabled");

   a_alarm_clears: assert property ( // RQ16
      s_reg.mode[0].hold == led_pkg::HOLD_ALARM && alarm && s_reg.held[0] && !trig[0]
      |=> !s_reg.held[0])
      else $error("alarm did not clear alarm-ack indicator");

   a_active_colour: assert property ( // RQ5
      shown[0] && s_reg.mode[0].on_colour_code == led_pkg::COL_RED
      |=> IND_RED[0] && !IND_GREEN[0])
      else $error("active colour not shown");

   a_idle_colour: assert property ( // RQ6
      !shown[0] && s_reg.mode[0].off_colour_code == led_pkg::COL_GREEN
      |=> IND_GREEN[0] && !IND_RED[0])
      else $error("inactive colour not shown");

   a_flash_follow: assert property ( // RQ19
      !shown[0] && s_reg.mode[0].off_colour_code == led_pkg::COL_GREEN_FL
      |=> IND_GREEN[0] == $past(s_reg.flash) && !IND_RED[0])
      else $error("flashing code not tied to shared flash");

   a_boot_contact: assert property ( // RQ18
      !started || s_reg.pin_s2[`PIN_FAULT] |=> !SUPERVISION_CONTACT)
      else $error("contact energised during boot or fault");

   a_boot_health: assert property ( // RQ17
      !started |=> HEALTH_GREEN == $past(s_reg.flash))
      else $error("health indicator not flashing in boot");

   a_set_held: assert property ( // RQ8
      s_reg.mode[0].hold != led_pkg::HOLD_OFF && trig[0] |=> s_reg.held[0])
      else $error("active trigger did not set held state");

   a_empty_clears: assert property ( // RQ10
      s_reg.mode[0].hold != led_pkg::HOLD_OFF && !assigned[0] |=> !s_reg.held[0])
      else $error("empty slots did not clear held state");

   a_own_ack_clears: assert property ( // RQ11
      s_reg.mode[0].hold == led_pkg::HOLD_ON && s_reg.mode[0].ack_used &&
      s_reg.sig_s2[s_reg.mode[0].ack_sel] && !trig[0] |=> !s_reg.held[0])
      else $error("own ack signal did not clear indicator");

   a_global_clears: assert property ( // RQ14
      s_reg.group_en && s_reg.glb_used && s_reg.sig_s2[s_reg.glb_sel] &&
      s_reg.mode[0].hold != led_pkg::HOLD_OFF && !trig[0] |=> !s_reg.held[0])
      else $error("global ack did not clear indicator");

   a_scada_clears: assert property ( // RQ15
      s_reg.group_en && s_reg.scada && s_reg.mode[0].hold != led_pkg::HOLD_OFF &&
      !trig[0] |=> !s_reg.held[0])
      else $error("SCADA ack did not clear indicator");

   a_scada_pulse: assert property ( // RQ15
      s_reg.scada |=> !s_reg.scada)
      else $error("SCADA ack lasted more than one cycle");

   a_alarm_needs_mode: assert property ( // RQ16
      s_reg.mode[0].hold == led_pkg::HOLD_ON && alarm && !panel_ack && !group_ack &&
      !(s_reg.mode[0].ack_used && s_reg.sig_s2[s_reg.mode[0].ack_sel]) &&
      assigned[0] && s_reg.held[0] |=> s_reg.held[0])
      else $error("alarm cleared indicator without alarm-ack mode");

   a_health_steady: assert property ( // RQ17
      started && s_reg.pin_s2[`PIN_PROT] |=> HEALTH_GREEN)
      else $error("health indicator not steady once protecting");

   a_contact_on: assert property ( // RQ18
      started && s_reg.pin_s2[`PIN_PROT] && !s_reg.pin_s2[`PIN_FAULT]
      |=> SUPERVISION_CONTACT)
      else $error("contact not energised when healthy");

   a_flash_rate: assert property ( // RQ19
      s_reg.fcnt != `FLASH_W'(FLASH_HALF_CYC - 1) |=> $stable(s_reg.flash))
      else $error("flash phase changed off its period");

   a_red_flash: assert property ( // RQ7
      !shown[0] && s_reg.mode[0].off_colour_code == led_pkg::COL_RED_FL
      |=> IND_RED[0] == $past(s_reg.flash) && !IND_GREEN[0])
      else $error("red flashing code not shown");

   a_dark_code: assert property ( // RQ7
      !shown[0] && s_reg.mode[0].off_colour_code == led_pkg::COL_OFF
      |=> !IND_RED[0] && !IND_GREEN[0])
      else $error("off code lit the indicator");

   a_one_colour: assert property ( // RQ7
      (IND_RED & IND_GREEN) == '0)
      else $error("indicator lit red and green at once");

   a_green_active: assert property ( // RQ5
      shown[0] && s_reg.mode[0].on_colour_code == led_pkg::COL_GREEN
      |=> IND_GREEN[0] && !IND_RED[0])
      else $error("green active code not shown");

   a_red_idle: assert property ( // RQ6
      !shown[0] && s_reg.mode[0].off_colour_code == led_pkg::COL_RED
      |=> IND_RED[0] && !IND_GREEN[0])
      else $error("red inactive code not shown");

   c_held_set: cover property (
      s_reg.mode[0].hold == led_pkg::HOLD_ON && trig[0] ##1 !trig[0] ##1 s_reg.held[0]);
   c_held_cleared: cover property (s_reg.held[0] ##1 !s_reg.held[0]);
   c_alarm_clear: cover property (alarm && s_reg.held[0] ##1 !s_reg.held[0]);
   c_contact_on: cover property (!SUPERVISION_CONTACT ##1 SUPERVISION_CONTACT);
   c_flash_edge: cover property (!s_reg.flash ##1 s_reg.flash);

endmodule // led_indicator_core

// ---- core/led_map.svh ----
// offsets, field positions and timing of the indicator block
// assumes a 20 MHz system clock and an 8-bit APB byte address
`ifndef LED_MAP_SVH
`define LED_MAP_SVH
`define NUM_IND        8
`define NUM_SIG        16
`define NUM_SLOT       5
`define REG_CTRL       8'h00
`define REG_STAT       8'h04
`define REG_ARR_BASE   8'h10
`define REG_ARR_END    8'h50
`define CTRL_GRP_EN    0
`define CTRL_SCADA     1
`define CTRL_GLB_USED  2
`define CTRL_GLB_LSB   3
`define STAT_SHOWN_LSB 8
`define STAT_STARTED   16
`define STAT_CONTACT   17
`define PIN_KEY        0
`define PIN_ALARM      1
`define PIN_START      2
`define PIN_PROT       3
`define PIN_FAULT      4
`define NUM_PIN        5
`define CLK_HZ         20000000
`define FLASH_HALF_MS  250
`define FLASH_W        23
`endif

// ---- core/led_pkg.sv ----
// types of the indicator block: colour codes, hold modes, config and state
// assumes led_map.svh is on the include path
package led_pkg;
`include "led_map.svh"
   typedef enum logic [2:0] {
      COL_OFF      = 3'h0,
      COL_GREEN    = 3'h1,
      COL_RED      = 3'h2,
      COL_RED_FL   = 3'h3,
      COL_GREEN_FL = 3'h4
   } colour_t;
   typedef enum logic [1:0] {
      HOLD_OFF   = 2'h0,
      HOLD_ON    = 2'h1,
      HOLD_ALARM = 2'h2
   } hold_t;
   typedef struct packed {
      logic       used;
      logic       inv;
      logic [3:0] sel;
   } slot_t;
   typedef slot_t [`NUM_SLOT-1:0] slots_t;
   typedef struct packed {
      colour_t    off_colour_code;
      colour_t    on_colour_code;
      logic [3:0] ack_sel;
      logic       ack_used;
      hold_t      hold;
   } mode_t;
   typedef struct packed {
      logic [`NUM_SIG-1:0]            sig_s1;
      logic [`NUM_SIG-1:0]            sig_s2;
      logic [`NUM_PIN-1:0]            pin_s1;
      logic [`NUM_PIN-1:0]            pin_s2;
      slots_t [`NUM_IND-1:0]          slots;
      mode_t [`NUM_IND-1:0]           mode;
      logic                           group_en;
      logic                           glb_used;
      logic [3:0]                     glb_sel;
      logic                           scada;
      logic [`NUM_IND-1:0]            held;
      logic [`NUM_IND-1:0]            grn;
      logic [`NUM_IND-1:0]            red;
      logic [`FLASH_W-1:0]            fcnt;
      logic                           flash;
      logic                           health;
      logic                           contact;
      logic [31:0]                    prdata;
      logic                           pslverr;
   } state_t;
endpackage
